// File: inc/vdm_pkg.sv
// Shared constants and types of the video decoder control slave
package vdm_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ         = 50000;
  localparam int unsigned BIT_RATE_KBPS   = 400;
  localparam int unsigned CYC_PER_BIT     = CLK_KHZ / BIT_RATE_KBPS;
  localparam int unsigned MIN_CYC_PER_BIT = 16;
  // ----------------------------------------------------------------
  // Slave address bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] WR_ADDR_DEF = 8'h42;
  localparam logic [7:0] WR_ADDR_ALT = 8'h40;
  localparam logic [7:0] RD_ADDR_DEF = 8'h43;
  localparam logic [7:0] RD_ADDR_ALT = 8'h41;
  // ----------------------------------------------------------------
  // Subaddress map
  // ----------------------------------------------------------------
  localparam logic [7:0] SUB_VERSION = 8'h00;
  localparam logic [7:0] FE_LO       = 8'h01;
  localparam logic [7:0] FE_HI       = 8'h05;
  localparam logic [7:0] DEC_LO      = 8'h06;
  localparam logic [7:0] DEC_HI      = 8'h19;
  localparam logic [7:0] DSTAT_0     = 8'h1e;
  localparam logic [7:0] DSTAT_1     = 8'h1f;
  localparam logic [7:0] AIN_LO      = 8'h23;
  localparam logic [7:0] AIN_HI      = 8'h25;
  localparam logic [7:0] COMP_LO     = 8'h29;
  localparam logic [7:0] COMP_HI     = 8'h2c;
  localparam logic [7:0] IMSK_LO     = 8'h2d;
  localparam logic [7:0] IMSK_HI     = 8'h2f;
  localparam logic [7:0] ACLK_LO     = 8'h30;
  localparam logic [7:0] ACLK_HI     = 8'h3a;
  localparam logic [7:0] SLC_LO      = 8'h40;
  localparam logic [7:0] SLC_HI      = 8'h5e;
  localparam logic [7:0] SLS_LO      = 8'h60;
  localparam logic [7:0] SLS_HI      = 8'h62;
  localparam logic [7:0] GLB_LO      = 8'h80;
  localparam logic [7:0] GLB_HI      = 8'h8f;
  localparam logic [7:0] TSKA_LO     = 8'h90;
  localparam logic [7:0] TSKA_HI     = 8'hbf;
  localparam logic [7:0] TSKB_LO     = 8'hc0;
  localparam logic [7:0] TSKB_HI     = 8'hef;
  localparam logic [7:0] RSVD_LO     = 8'hf0;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] VERSION_DEF = 8'h5a; // Arbitrary value
  localparam logic [3:0] BITS_BYTE   = 4'h8;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_ADDR  = 4'b0001,
    ST_AACK  = 4'b0010,
    ST_SUB   = 4'b0011,
    ST_SACK  = 4'b0100,
    ST_WDAT  = 4'b0101,
    ST_WACK  = 4'b0110,
    ST_RDAT  = 4'b0111,
    ST_RACK  = 4'b1000
  } vdm_state_t;
endpackage : vdm_pkg

// File: inc/vdm_reg_if.sv
// Register access carrier between serial engine and register map
`timescale 1ns/1ns
interface vdm_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic [7:0] rdata;
  logic       wr_ok;
  modport eng (output addr, output wdata, output wr, input rdata, input wr_ok);
  modport map (input addr, input wdata, input wr, output rdata, output wr_ok);
endinterface : vdm_reg_if

// File: core/vdm_regmap.sv
// Byte-wide subaddress map with read-write, read-only and reserved ranges
`timescale 1ns/1ns
module vdm_regmap
  import vdm_pkg::*;
#(
  parameter logic [7:0] CHIP_VERSION = VERSION_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  vdm_reg_if.map           bus,
  input  wire logic [7:0]  dstat0_i,
  input  wire logic [7:0]  dstat1_i,
  input  wire logic [23:0] slc_stat_i
);
  typedef struct packed {
    logic [255:0][7:0] mem;
  } vdm_map_t;

  vdm_map_t   r;
  vdm_map_t   next_r;
  logic [255:0] rw_map;

  function automatic logic vdm_is_rw(input logic [7:0] a);
    vdm_is_rw = 1'b0;
    if (a >= FE_LO && a <= FE_HI) vdm_is_rw = 1'b1;
    if (a >= DEC_LO && a <= DEC_HI) vdm_is_rw = 1'b1;
    if (a >= AIN_LO && a <= AIN_HI) vdm_is_rw = 1'b1;
    if (a >= COMP_LO && a <= COMP_HI) vdm_is_rw = 1'b1;
    if (a >= IMSK_LO && a <= IMSK_HI) vdm_is_rw = 1'b1;
    if (a >= ACLK_LO && a <= ACLK_HI) vdm_is_rw = 1'b1;
    if (a >= SLC_LO && a <= SLC_HI) vdm_is_rw = 1'b1;
    if (a >= GLB_LO && a <= GLB_HI) vdm_is_rw = 1'b1;
    if (a >= TSKA_LO && a <= TSKA_HI) vdm_is_rw = 1'b1;
    if (a >= TSKB_LO && a <= TSKB_HI) vdm_is_rw = 1'b1;
  endfunction : vdm_is_rw

  for (genvar i = 0; i < 256; i++) begin : g_acc
    assign rw_map[i] = vdm_is_rw(8'(i));
  end

  // Read-only and reserved entries take no write, still acknowledged
  assign bus.wr_ok = rw_map[bus.addr];

  always_comb begin
    if (bus.addr == SUB_VERSION) begin
      bus.rdata = CHIP_VERSION;
    end else if (bus.addr == DSTAT_0) begin
      bus.rdata = dstat0_i;
    end else if (bus.addr == DSTAT_1) begin
      bus.rdata = dstat1_i;
    end else if (bus.addr >= SLS_LO && bus.addr <= SLS_HI) begin
      bus.rdata = slc_stat_i[8*(bus.addr - SLS_LO) +: 8];
    end else if (rw_map[bus.addr]) begin
      bus.rdata = r.mem[bus.addr];
    end else begin
      bus.rdata = 8'h00;
    end
  end

  always_comb begin
    next_r = r;
    if (bus.wr && rw_map[bus.addr]) begin
      next_r.mem[bus.addr] = bus.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= {256{REG_RESET}};
    end else begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_rw_store: assert property (bus.wr && rw_map[bus.addr] |=>
    r.mem[$past(bus.addr)] == $past(bus.wdata)) else $error("rw write not stored");
  a_ro_ignore: assert property (bus.wr && !bus.wr_ok |=> $stable(r.mem))
    else $error("write to read-only entry changed storage");
  a_rsvd_zero: assert property (bus.addr >= RSVD_LO |-> bus.rdata == 8'h00)
    else $error("reserved entry reads nonzero");
endmodule : vdm_regmap

// File: core/vdm_i2c_slave.sv
// Serial control slave of the video decoder with its subaddress map
`timescale 1ns/1ns
module vdm_i2c_slave
  import vdm_pkg::*;
#(
  parameter int unsigned CLK_KHZ_P    = CLK_KHZ,
  parameter logic [7:0]  CHIP_VERSION = VERSION_DEF
) (
  input  wire logic        MCLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output wire logic        SDA_O,
  output wire logic        SDA_OE_O,
  input  wire logic        ADDR_SEL_STRAP_I,
  input  wire logic [7:0]  DEC_STATUS_0_I,
  input  wire logic [7:0]  DEC_STATUS_1_I,
  input  wire logic [23:0] SLICER_STATUS_I,
  output wire logic        WR_STB_O,
  output wire logic [7:0]  WR_ADDR_O,
  output wire logic [7:0]  WR_DATA_O
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Edge detection needs several clocks per bit at the fastest bus rate
  if (CLK_KHZ_P / BIT_RATE_KBPS < MIN_CYC_PER_BIT) begin : g_chk
    $error("clock too slow for fast-mode bit rate");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    vdm_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic       rd;
    logic       mack;
    logic       scl_q;
    logic       sda_q;
    logic       sda_o;
    logic       sda_oe;
    logic       strap_done;
    logic       strap_sel;
    logic       wr;
    logic [7:0] wdata;
    logic       wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } vdm_eng_t;

  vdm_eng_t   r;
  vdm_eng_t   next_r;
  vdm_reg_if  u_bus();

  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;
  logic [7:0] wr_match;
  logic [7:0] rd_match;

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  // Pins arrive synchronous; the previous sample gives the edges
  assign scl_rise = SCL_I && !r.scl_q;
  assign scl_fall = !SCL_I && r.scl_q;
  assign start    = SCL_I && r.scl_q && r.sda_q && !SDA_I;
  assign stop     = SCL_I && r.scl_q && !r.sda_q && SDA_I;

  assign wr_match = r.strap_sel ? WR_ADDR_ALT : WR_ADDR_DEF;
  assign rd_match = r.strap_sel ? RD_ADDR_ALT : RD_ADDR_DEF;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  assign u_bus.addr  = r.ptr;
  assign u_bus.wdata = r.wdata;
  assign u_bus.wr    = r.wr;

  vdm_regmap #(
    .CHIP_VERSION (CHIP_VERSION)
  ) u_map (
    .clk_i      (MCLK_I),
    .rst_i      (SYS_RST_I),
    .bus        (u_bus),
    .dstat0_i   (DEC_STATUS_0_I),
    .dstat1_i   (DEC_STATUS_1_I),
    .slc_stat_i (SLICER_STATUS_I)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.scl_q  = SCL_I;
    next_r.sda_q  = SDA_I;
    next_r.sda_o  = 1'b0;
    next_r.wr     = 1'b0;
    next_r.wr_stb = 1'b0;

    // Strap is caught once, the cycle after reset release
    if (!r.strap_done) begin
      next_r.strap_done = 1'b1;
      next_r.strap_sel  = ADDR_SEL_STRAP_I;
    end

    // Write issued last cycle: mirror it out and step the pointer
    if (r.wr) begin
      next_r.wr_stb  = u_bus.wr_ok;
      next_r.wr_addr = r.ptr;
      next_r.wr_data = r.wdata;
      next_r.ptr     = r.ptr + 8'h01;
    end

    if (stop) begin
      next_r.st     = ST_IDLE;
      next_r.sda_oe = 1'b0;
    end else if (start) begin
      // A start inside a transfer is the repeated start
      next_r.st     = ST_ADDR;
      next_r.bitcnt = 4'h0;
      next_r.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (r.st)
        ST_ADDR, ST_SUB, ST_WDAT: begin
          if (r.bitcnt < BITS_BYTE) begin
            next_r.shift  = {r.shift[6:0], SDA_I};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end
        end
        ST_RACK: begin
          next_r.mack = !SDA_I;
          if (!SDA_I) begin
            next_r.ptr = r.ptr + 8'h01;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (r.st)
        ST_ADDR: begin
          if (r.bitcnt == BITS_BYTE) begin
            if (r.shift == wr_match || r.shift == rd_match) begin
              next_r.st     = ST_AACK;
              next_r.rd     = r.shift[0];
              next_r.sda_oe = 1'b1;
            end else begin
              // Another slave is addressed; wait for the next start
              next_r.st = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          next_r.bitcnt = 4'h0;
          if (r.rd) begin
            next_r.st     = ST_RDAT;
            next_r.sda_oe = !u_bus.rdata[7];
            next_r.shift  = {u_bus.rdata[6:0], 1'b0};
            next_r.bitcnt = 4'h1;
          end else begin
            next_r.st     = ST_SUB;
            next_r.sda_oe = 1'b0;
          end
        end
        ST_SUB: begin
          if (r.bitcnt == BITS_BYTE) begin
            next_r.st     = ST_SACK;
            next_r.ptr    = r.shift;
            next_r.sda_oe = 1'b1;
          end
        end
        ST_SACK, ST_WACK: begin
          next_r.st     = ST_WDAT;
          next_r.bitcnt = 4'h0;
          next_r.sda_oe = 1'b0;
        end
        ST_WDAT: begin
          if (r.bitcnt == BITS_BYTE) begin
            next_r.st     = ST_WACK;
            next_r.wr     = 1'b1;
            next_r.wdata  = r.shift;
            next_r.sda_oe = 1'b1;
          end
        end
        ST_RDAT: begin
          if (r.bitcnt == BITS_BYTE) begin
            next_r.st     = ST_RACK;
            next_r.sda_oe = 1'b0;
          end else begin
            next_r.sda_oe = !r.shift[7];
            next_r.shift  = {r.shift[6:0], 1'b0};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end
        end
        ST_RACK: begin
          if (r.mack) begin
            next_r.st     = ST_RDAT;
            next_r.sda_oe = !u_bus.rdata[7];
            next_r.shift  = {u_bus.rdata[6:0], 1'b0};
            next_r.bitcnt = 4'h1;
          end else begin
            // No acknowledge ends the read; bus left to the master
            next_r.st = ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      r            <= '0;
      r.st         <= ST_IDLE;
      r.scl_q      <= 1'b1;
      r.sda_q      <= 1'b1;
      r.ptr        <= SUB_VERSION;
    end else begin
      r <= next_r;
    end
  end

  assign SDA_O     = r.sda_o;
  assign SDA_OE_O  = r.sda_oe;
  assign WR_STB_O  = r.wr_stb;
  assign WR_ADDR_O = r.wr_addr;
  assign WR_DATA_O = r.wr_data;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_byte_end(vdm_state_t s);
    scl_fall && !start && !stop && r.st == s && r.bitcnt == BITS_BYTE;
  endsequence

  sequence s_ack_low(vdm_state_t s);
    r.st == s && r.sda_oe;
  endsequence

  a_wr_addr_ack: assert property (s_byte_end(ST_ADDR) and
    (r.shift == (r.strap_sel ? WR_ADDR_ALT : WR_ADDR_DEF)) |=> s_ack_low(ST_AACK) ##0 !r.rd)
    else $error("write address not acknowledged");

  a_rd_addr_ack: assert property (s_byte_end(ST_ADDR) and
    (r.shift == (r.strap_sel ? RD_ADDR_ALT : RD_ADDR_DEF)) |=> s_ack_low(ST_AACK) ##0 r.rd)
    else $error("read address not acknowledged");

  a_foreign_addr: assert property (s_byte_end(ST_ADDR) and
    (r.shift[7:2] != 6'h10) |=> r.st == ST_IDLE && !r.sda_oe)
    else $error("foreign address acknowledged");

  a_strap_catch: assert property (!r.strap_done |=>
    r.strap_done && r.strap_sel == $past(ADDR_SEL_STRAP_I) ##1 $stable(r.strap_sel))
    else $error("strap not caught after reset");

  a_sub_ack: assert property (s_byte_end(ST_SUB) |=>
    s_ack_low(ST_SACK) ##0 r.ptr == $past(r.shift))
    else $error("subaddress not acknowledged or not loaded");

  a_data_ack: assert property (s_byte_end(ST_WDAT) |=>
    s_ack_low(ST_WACK) ##0 r.wr ##1 !r.wr)
    else $error("data byte not acknowledged or write not one cycle");

  a_ptr_step: assert property (r.wr |=> r.ptr == $past(r.ptr) + 8'h01)
    else $error("pointer did not advance after write");

  a_ignored_wr: assert property (r.wr && !u_bus.wr_ok |=> !r.wr_stb)
    else $error("ignored write reported as stored");

  a_read_cont: assert property (scl_fall && !start && !stop &&
    r.st == ST_RACK && r.mack |=> r.st == ST_RDAT && r.bitcnt == 4'h1)
    else $error("read not continued after master acknowledge");

  a_stop_release: assert property (stop |=> r.st == ST_IDLE && !r.sda_oe)
    else $error("stop did not release the bus");

  a_rd_release: assert property (s_byte_end(ST_RDAT) |=> r.st == ST_RACK && !r.sda_oe)
    else $error("data line held during master acknowledge");
endmodule : vdm_i2c_slave

// File: tb/vdm_i2c_master.sv
// Serial bus master model facing the control slave
`timescale 1ns/1ns
module vdm_i2c_master (
  input  wire logic       clk_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] quarter_i,
  output logic            scl_o,
  output logic            sda_oe_o
);
  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Quarter bit; 32 gives 128 clocks per bit, just under fast mode
  task automatic q_wait();
    repeat (quarter_i) @(negedge clk_i);
  endtask : q_wait

  // Serves as start and repeated start; data released while clock low, then pulled low while clock high
  task automatic start_c();
    sda_oe_o = 1'b0;
    q_wait();
    scl_o = 1'b1;
    q_wait();
    sda_oe_o = 1'b1;
    q_wait();
    scl_o = 1'b0;
    q_wait();
  endtask : start_c

  task automatic stop_c();
    sda_oe_o = 1'b1;
    q_wait();
    scl_o = 1'b1;
    q_wait();
    sda_oe_o = 1'b0;
    q_wait();
  endtask : stop_c

  // A one bit releases the line, so it also reads the slave
  task automatic bit_c(input logic b, output logic r);
    sda_oe_o = !b;
    q_wait();
    scl_o = 1'b1;
    q_wait();
    r = sda_i;
    q_wait();
    scl_o = 1'b0;
    q_wait();
  endtask : bit_c

  // Ninth bit is the acknowledge slot, driven or released by caller
  task automatic byte_c(input logic [7:0] d, input logic nb, output logic [7:0] r,
                        output logic s);
    for (int i = 7; i >= 0; i--) bit_c(d[i], r[i]);
    bit_c(nb, s);
  endtask : byte_c
endmodule : vdm_i2c_master

// File: tb/video_decoder_i2c_slave_map_bench.sv
// Self-checking bench of the serial control slave and its map
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); \
  n_fail++; end end
module video_decoder_i2c_slave_map_bench;
  // ----------------------------------------------------------------
  // Stimulus and harness
  // ----------------------------------------------------------------
  localparam logic [7:0]  DS0 = 8'h6e;
  localparam logic [7:0]  DS1 = 8'h91;
  localparam logic [23:0] SLC = 24'hb72d4c;
  // Kind, subaddress, read value; kind 0 read-write, 1 read-only, 2 reserved
  localparam logic [17:0] ROWS [28] = '{
    18'h00100, 18'h01900, 18'h02300, 18'h02500, 18'h02900, 18'h02f00, 18'h03000,
    18'h03a00, 18'h04000, 18'h05e00, 18'h08000, 18'h08f00, 18'h09000, 18'h0bf00,
    18'h0c000, 18'h0ef00, 18'h1003c, 18'h11e6e, 18'h11f91, 18'h1604c, 18'h162b7,
    18'h21d00, 18'h22000, 18'h22600, 18'h23f00, 18'h25f00, 18'h26300, 18'h2ff00};
  logic        clk;
  logic        rst;
  logic        strap;
  logic [7:0]  quarter;
  logic        scl;
  logic        m_oe;
  wire logic   sda;
  wire logic   s_o;
  wire logic   s_oe;
  wire logic   stb;
  wire logic [7:0] w_addr;
  wire logic [7:0] w_data;
  logic [7:0]  wbuf [8];
  logic [7:0]  rbuf [8];
  logic [15:0] stb_q [$];
  logic [15:0] exp_q [$];
  int          n_fail;
  int          n_checks;
  int          cyc;

  // Open drain with pull-up: low whenever either side pulls
  assign sda = ~(s_oe | m_oe);

  initial clk = 1'b0;
  always #10 clk = ~clk;

  vdm_i2c_slave #(.CHIP_VERSION(8'h3c)) vdm_i2c_slave_i (
    .MCLK_I(clk), .SYS_RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(s_o),
    .SDA_OE_O(s_oe), .ADDR_SEL_STRAP_I(strap), .DEC_STATUS_0_I(DS0),
    .DEC_STATUS_1_I(DS1), .SLICER_STATUS_I(SLC), .WR_STB_O(stb),
    .WR_ADDR_O(w_addr), .WR_DATA_O(w_data));

  vdm_i2c_master vdm_i2c_master_i (
    .clk_i(clk), .sda_i(sda), .quarter_i(quarter), .scl_o(scl), .sda_oe_o(m_oe));

  // Falling edge sampling keeps clear of the strobe's own launch edge
  always @(negedge clk) if (stb === 1'b1) stb_q.push_back({w_addr, w_data});

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask : do_reset

  task automatic put(input logic [7:0] d, input logic ack);
    logic [7:0] r;
    logic       s;
    vdm_i2c_master_i.byte_c(d, 1'b1, r, s);
    `CHK(s, !ack)
  endtask : put

  task automatic wr_t(input logic [7:0] a, input logic [7:0] sub, input int n);
    vdm_i2c_master_i.start_c();
    put(a, 1'b1);
    put(sub, 1'b1);
    for (int i = 0; i < n; i++) put(wbuf[i], 1'b1);
    vdm_i2c_master_i.stop_c();
  endtask : wr_t

  // Last byte is refused by the master so the slave lets go of the line
  task automatic rd_t(input logic [7:0] wa, input logic [7:0] ra, input logic [7:0] sub,
                      input int n);
    logic s;
    vdm_i2c_master_i.start_c();
    put(wa, 1'b1);
    put(sub, 1'b1);
    vdm_i2c_master_i.start_c();
    put(ra, 1'b1);
    for (int i = 0; i < n; i++) vdm_i2c_master_i.byte_c(8'hff, i == n - 1, rbuf[i], s);
    vdm_i2c_master_i.stop_c();
  endtask : rd_t

  task automatic chk_stb();
    `CHK(stb_q.size(), exp_q.size())
    for (int i = 0; i < exp_q.size() && i < stb_q.size(); i++) `CHK(stb_q[i], exp_q[i])
    stb_q.delete();
    exp_q.delete();
  endtask : chk_stb

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] k;
    logic [7:0] s;
    logic [7:0] e;
    rst = 1'b1;
    strap = 1'b0;
    quarter = 8'h20;
    n_fail = 0;
    n_checks = 0;
    cyc = 0;
    do_reset();
    `CHK(s_oe, 1'b0)
    `CHK(s_o, 1'b0)
    `CHK(stb, 1'b0)
    `CHK(w_addr, 8'h00)
    wbuf[0] = 8'h11;
    wbuf[1] = 8'h22;
    exp_q.push_back(16'h1011);
    exp_q.push_back(16'h1122);
    wr_t(8'h42, 8'h10, 2);
    chk_stb();
    // Map sweep at 32 clocks per bit, twice the slave's minimum, to keep the run short
    quarter = 8'h08;
    for (int i = 0; i < 28; i++) begin
      k = ROWS[i][17:16];
      s = ROWS[i][15:8];
      wbuf[0] = s ^ 8'hc3;
      if (k == 2'd0) exp_q.push_back({s, wbuf[0]});
      wr_t(8'h42, s, 1);
      chk_stb();
      rd_t(8'h42, 8'h43, s, 1);
      e = (k == 2'd0) ? wbuf[0] : ROWS[i][7:0];
      `CHK(rbuf[0], e)
    end
    wbuf[0] = 8'ha1;
    wbuf[1] = 8'ha2;
    wbuf[2] = 8'ha3;
    wbuf[3] = 8'ha4;
    exp_q.push_back(16'h01a4);
    wr_t(8'h42, 8'hfe, 4);
    chk_stb();
    rd_t(8'h42, 8'h43, 8'h01, 1);
    `CHK(rbuf[0], 8'ha4)
    rd_t(8'h42, 8'h43, 8'h1e, 3);
    `CHK(rbuf[0], DS0)
    `CHK(rbuf[1], DS1)
    `CHK(rbuf[2], 8'h00)
    vdm_i2c_master_i.start_c();
    put(8'h44, 1'b0);
    vdm_i2c_master_i.stop_c();
    vdm_i2c_master_i.start_c();
    put(8'h41, 1'b0);
    vdm_i2c_master_i.stop_c();
    strap = 1'b1;
    do_reset();
    `CHK(w_addr, 8'h00)
    `CHK(s_o, 1'b0)
    vdm_i2c_master_i.start_c();
    put(8'h42, 1'b0);
    vdm_i2c_master_i.stop_c();
    wbuf[0] = 8'h5c;
    exp_q.push_back(16'h315c);
    wr_t(8'h40, 8'h31, 1);
    chk_stb();
    rd_t(8'h40, 8'h41, 8'h31, 1);
    `CHK(rbuf[0], 8'h5c)
    end_of_test();
  end
endmodule : video_decoder_i2c_slave_map_bench
